// ==== design/dec_ecc_ctrl.sv ====
// module: ecc generation, checking, correction, scrub and error logging
`timescale 1ns/100ps
// Function
// - two-bit error_signal_enable; low bit multi-bit, high bit single-bit to serr
// - serr needs pci command system-error enable too
// - diagnostic enable writes check byte zero on every write
// - diagnostic partial writes still do rmw but store zero check byte
// - diagnostic reads checked and logged but never corrected
// - processor reads get raw data and stored check bits
// - ecc disabled: no check bits, no correction
// - check_only_mode checks and reports, returns raw data, no extra clock
// - check_correct_mode corrects single-bit errors with one extra clock
// - correcting modes store check byte and do rmw on partial writes
// - scrub mode writes corrected value back on single-bit error
// - mode may change on the fly without reset
// - status field: low bit multi-bit detect, high bit single-bit detect
// - flags and chip select logged on first error of each type only
// - logged type blocks new logging and serr until write-one clear
// - multibit_fail_chipsel holds chip select of first multi-bit error
// - singlebit_fail_chipsel holds chip select of first single-bit error
// - one hamming check byte per 64-bit quadword written
// - reads recompute, correct single errors, detect multi-bit errors
// - partial write: read, correct, merge bytes, new check byte, write
module dec_ecc_ctrl (
    input wire logic clk_i,
    input wire logic nrst_i,
    // configuration
    input wire logic [1:0] correction_mode_select_i,
    input wire logic [1:0] error_signal_enable_i,
    input wire logic pci_error_signal_enable_i,
    input wire logic diag_enable_i,
    input wire logic [1:0] status_clear_i,
    // write request from the bridge
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [63:0] wr_data_i,
    input wire logic [7:0] wr_be_i,
    input wire logic [2:0] wr_cs_i,
    input wire logic wr_cpu_i,
    input wire logic [7:0] wr_cpu_chk_i,
    // read request from the bridge
    input wire logic rd_valid_i,
    output logic rd_ready_o,
    input wire logic [2:0] rd_cs_i,
    input wire logic rd_cpu_i,
    // memory side
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [2:0] mem_cs_o,
    output logic [63:0] mem_wdata_o,
    output logic [7:0] mem_wchk_o,
    input wire logic mem_rvalid_i,
    input wire logic [63:0] mem_rdata_i,
    input wire logic [7:0] mem_rchk_i,
    // read return
    output logic rd_done_o,
    output logic [63:0] rd_data_o,
    output logic [7:0] rd_chk_o,
    // status
    output logic [1:0] error_status_o,
    output logic [2:0] multibit_fail_chipsel_o,
    output logic [2:0] singlebit_fail_chipsel_o,
    output logic serr_n_o
);
    // ----------------------------------------------------------------
    // state and registered copy
    // ----------------------------------------------------------------
    // one transaction at a time; the bridge holds off while ready is low
    typedef enum logic [2:0] {
        DEC_IDLE,
        DEC_RD_WAIT,
        DEC_RD_FIX,
        DEC_RMW_WAIT,
        DEC_RMW_WRITE,
        DEC_SCRUB
    } dec_state_t;

    typedef struct packed {
        dec_state_t state;
        logic [63:0] data;
        logic [7:0] be;
        logic [2:0] cs;
        logic cpu;
        logic [7:0] cpu_chk;
        logic fast;
        logic [63:0] raw;
        logic [7:0] rchk;
        logic mem_rd;
        logic mem_wr;
        logic [63:0] wdata;
        logic [7:0] wchk;
        logic rd_done;
        logic [63:0] rd_data;
        logic [7:0] rd_chk;
        logic [1:0] status;
        logic [2:0] cs_multi;
        logic [2:0] cs_single;
        logic serr;
    } dec_reg_t;

    // every flip-flop of the block lives in this one copy
    dec_reg_t r;
    dec_reg_t next_r;

    // ----------------------------------------------------------------
    // decode of the mode bits
    // ----------------------------------------------------------------
    dec_pkg::dec_mode_t mode;
    logic ecc_on;
    logic correct_on;
    logic scrub_on;

    // diagnostic mode turns correction off but leaves checking alone, so a
    // zero check byte written on purpose is still reported on read back
    // mode is sampled live so software may switch it at any time
    always_comb begin
        mode = dec_pkg::dec_mode_t'(correction_mode_select_i);
        ecc_on = mode != dec_pkg::DEC_MODE_DISABLED;
        correct_on = !diag_enable_i && (mode == dec_pkg::DEC_MODE_CHECK_CORRECT
            || mode == dec_pkg::DEC_MODE_CHECK_CORRECT_SCRUB);
        scrub_on = correct_on && mode == dec_pkg::DEC_MODE_CHECK_CORRECT_SCRUB;
    end

    // ----------------------------------------------------------------
    // hamming units: one on the memory read path, one on write data
    // ----------------------------------------------------------------
    logic [63:0] rd_fixed;
    logic rd_single;
    logic rd_multi;
    logic [7:0] gen_unused;
    logic [63:0] merged;
    logic [7:0] wr_gen;

    // the check unit watches the captured word, never the live bus,
    // so its syndrome has the whole clock after capture to settle before it is used
    dec_hamming u_check (
        .data_i(r.raw),
        .chk_i(r.rchk),
        .chk_o(gen_unused),
        .fixed_o(rd_fixed),
        .single_o(rd_single),
        .multi_o(rd_multi)
    );

    // the generator's check input is unused; tied to the zero code
    dec_hamming u_gen (
        .data_i(merged),
        .chk_i(dec_pkg::DIAG_CHECK),
        .chk_o(wr_gen),
        .fixed_o(),
        .single_o(),
        .multi_o()
    );

    // with ecc off a partial write is not read first, so bytes outside
    // the enables come from the last captured word; keep such writes full
    // byte merge of new write bytes over the corrected quadword, or the raw one when correction is off
    always_comb begin
        merged = (r.state == dec_state_t'(DEC_SCRUB)) ? rd_fixed : r.data;
        if (r.state == DEC_RMW_WRITE) begin
            for (int b = 0; b < dec_pkg::BE_W; b++) begin
                merged[b*8 +: 8] = r.be[b] ? r.data[b*8 +: 8]
                    : (correct_on ? rd_fixed[b*8 +: 8] : r.raw[b*8 +: 8]);
            end
        end
    end

    // check byte to store: zero in diagnostic mode, nothing when ecc is off
    function automatic logic [7:0] store_chk(input logic [7:0] g);
        if (diag_enable_i) begin
            return dec_pkg::DIAG_CHECK;
        end
        return ecc_on ? g : dec_pkg::DIAG_CHECK;
    endfunction : store_chk

    logic chk_event;
    logic hit_single;
    logic hit_multi;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // one process fills the whole next copy of the state
    always_comb begin
        next_r = r;
        next_r.mem_rd = 1'b0;
        next_r.mem_wr = 1'b0;
        next_r.rd_done = 1'b0;
        chk_event = 1'b0;
        wr_ready_o = 1'b0;
        rd_ready_o = 1'b0;
        case (r.state)
            DEC_IDLE: begin
                // writes win over reads when both arrive together
                // a steady write stream can hold reads off; the bridge spaces them
                if (wr_valid_i) begin
                    wr_ready_o = 1'b1;
                    next_r.data = wr_data_i;
                    next_r.be = wr_be_i;
                    next_r.cs = wr_cs_i;
                    next_r.cpu = wr_cpu_i;
                    next_r.cpu_chk = wr_cpu_chk_i; // taken with the request
                    if (wr_be_i != dec_pkg::BE_FULL && ecc_on) begin
                        next_r.mem_rd = 1'b1;
                        next_r.state = DEC_RMW_WAIT;
                    end else begin
                        next_r.state = DEC_RMW_WRITE;
                    end
                end else if (rd_valid_i) begin
                    rd_ready_o = 1'b1;
                    next_r.cs = rd_cs_i;
                    next_r.cpu = rd_cpu_i;
                    next_r.mem_rd = 1'b1;
                    next_r.state = DEC_RD_WAIT;
                end
            end
            DEC_RD_WAIT: begin
                if (mem_rvalid_i) begin
                    next_r.raw = mem_rdata_i;
                    next_r.rchk = mem_rchk_i;
                    next_r.state = DEC_RD_FIX;
                    // uncorrected returns skip the correction clock
                    next_r.fast = r.cpu || !correct_on;
                    if (r.cpu || !correct_on) begin
                        next_r.rd_done = 1'b1;
                        next_r.rd_data = mem_rdata_i;
                        next_r.rd_chk = mem_rchk_i;
                    end
                end
            end
            DEC_RD_FIX: begin
                // captured word is checked here; correction costs this clock
                chk_event = ecc_on;
                // the path chosen a clock ago stands even if the mode moved since
                if (!r.fast) begin
                    next_r.rd_done = 1'b1;
                    next_r.rd_chk = r.rchk;
                    next_r.rd_data = rd_fixed;
                end
                // scrub processor reads too: the stored word is bad either way
                if (scrub_on && rd_single && !r.cpu) begin
                    next_r.state = DEC_SCRUB;
                end else if (scrub_on && rd_single) begin
                    next_r.state = DEC_SCRUB;
                end else begin
                    next_r.state = DEC_IDLE;
                end
            end
            DEC_RMW_WAIT: begin
                // the old word is captured here and checked in the write cycle
                if (mem_rvalid_i) begin
                    next_r.raw = mem_rdata_i;
                    next_r.rchk = mem_rchk_i;
                    next_r.state = DEC_RMW_WRITE;
                end
            end
            DEC_RMW_WRITE: begin
                // only partial writes are checked, here in the write cycle, on the word their read half captured
                chk_event = ecc_on && r.be != dec_pkg::BE_FULL;
                next_r.mem_wr = 1'b1;
                next_r.wdata = merged;
                if (r.cpu && r.be == dec_pkg::BE_FULL && ecc_on && !diag_enable_i) begin
                    next_r.wchk = r.cpu_chk; // processor supplies its own code
                end else begin
                    next_r.wchk = store_chk(wr_gen);
                end
                next_r.state = DEC_IDLE;
            end
            DEC_SCRUB: begin
                // write-back of the corrected word, an extra memory cycle
                // the requester already has its data, so the write-back only
                // delays the next request by a clock
                next_r.mem_wr = 1'b1;
                next_r.wdata = rd_fixed;
                next_r.wchk = store_chk(wr_gen);
                next_r.state = DEC_IDLE;
            end
            default: begin
                next_r.state = DEC_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // first-error logging
        // ------------------------------------------------------------
        // set beats a same-cycle clear: a clear in the clock of a new error
        // re-arms the flag and logs that error at once
        hit_single = chk_event && rd_single
            && (!r.status[dec_pkg::SINGLE_BIT] || status_clear_i[dec_pkg::SINGLE_BIT]);
        hit_multi = chk_event && rd_multi
            && (!r.status[dec_pkg::MULTI_BIT] || status_clear_i[dec_pkg::MULTI_BIT]);
        next_r.status = r.status & ~status_clear_i;
        if (hit_single) begin
            next_r.status[dec_pkg::SINGLE_BIT] = 1'b1;
            next_r.cs_single = r.cs;
        end
        if (hit_multi) begin
            next_r.status[dec_pkg::MULTI_BIT] = 1'b1;
            next_r.cs_multi = r.cs;
        end
        // serr only for a newly logged error that is enabled
        // a repeat of a logged type raises no pulse until software clears it
        next_r.serr = pci_error_signal_enable_i
            && ((hit_multi && error_signal_enable_i[dec_pkg::MULTI_BIT])
            || (hit_single && error_signal_enable_i[dec_pkg::SINGLE_BIT]));
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // everything resets to zero, so no error shows after reset
    // the reset branch loads constants only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
            r.state <= DEC_IDLE;
            r.status <= dec_pkg::STATUS_RESET;
            r.cs_multi <= dec_pkg::CS_RESET;
            r.cs_single <= dec_pkg::CS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // outputs straight from flip-flops
    assign mem_rd_o = r.mem_rd;
    assign mem_wr_o = r.mem_wr;
    assign mem_cs_o = r.cs;
    assign mem_wdata_o = r.wdata;
    assign mem_wchk_o = r.wchk;
    assign rd_done_o = r.rd_done;
    assign rd_data_o = r.rd_data;
    assign rd_chk_o = r.rd_chk;
    assign error_status_o = r.status;
    assign multibit_fail_chipsel_o = r.cs_multi;
    assign singlebit_fail_chipsel_o = r.cs_single;
    assign serr_n_o = !r.serr;
endmodule : dec_ecc_ctrl

// ==== design/dec_hamming.sv ====
// module: secded hamming check byte generator and syndrome decoder
`timescale 1ns/100ps
module dec_hamming (
    input wire logic [63:0] data_i,
    input wire logic [7:0] chk_i,
    output logic [7:0] chk_o,
    output logic [63:0] fixed_o,
    output logic single_o,
    output logic multi_o
);
    // ----------------------------------------------------------------
    // code layout
    // ----------------------------------------------------------------
    // data bit d sits at codeword position pos(d), skipping powers of two;
    // bit 7 of the check byte is overall parity over data and checks.
    function automatic logic [6:0] pos_of(input int d);
        int p;
        int n;
        p = 0;
        n = -1;
        for (int k = 1; k < 128; k++) begin
            if ((k & (k - 1)) != 0 && n < d) begin
                n++;
                p = k;
            end
        end
        return p[6:0];
    endfunction : pos_of

    logic [6:0] syn;
    logic [6:0] gen;
    logic par;

    // check generation and syndrome
    always_comb begin
        gen = 7'h00;
        for (int d = 0; d < 64; d++) begin
            if (data_i[d]) begin
                gen = gen ^ pos_of(d);
            end
        end
        chk_o = {^{data_i, gen}, gen};
        syn = gen ^ chk_i[6:0];
        par = ^{data_i, chk_i};
        single_o = par;
        multi_o = !par && (syn != 7'h00);
        fixed_o = data_i;
        for (int d = 0; d < 64; d++) begin
            if (par && syn == pos_of(d)) begin
                fixed_o[d] = ~data_i[d];
            end
        end
    end
endmodule : dec_hamming

// ==== design/dec_pkg.sv ====
// package: constants and types for the ecc check and scrub block
package dec_pkg;
    localparam int DATA_W = 64;
    localparam int CHK_W = 8;
    localparam int CS_W = 3;
    localparam int BE_W = 8;
    // error_signal_enable / error status field bit positions
    localparam int MULTI_BIT = 0;
    localparam int SINGLE_BIT = 1;
    localparam logic [CHK_W-1:0] DIAG_CHECK = 8'h00;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [CS_W-1:0] CS_RESET = 3'h0;
    localparam logic [BE_W-1:0] BE_FULL = 8'hff;
    // correction_mode_select encoding
    typedef enum logic [1:0] {
        DEC_MODE_DISABLED = 2'h0,
        DEC_MODE_CHECK_ONLY = 2'h1,
        DEC_MODE_CHECK_CORRECT = 2'h2,
        DEC_MODE_CHECK_CORRECT_SCRUB = 2'h3
    } dec_mode_t;
endpackage : dec_pkg

// ==== tb/ddr_ecc_check_scrub_control_test.sv ====
// testbench: directed scenarios for the ecc check and scrub block
`timescale 1ns/100ps
module ddr_ecc_check_scrub_control_test;
    // ----------------------------------------
    // dut, dimm model and scenarios
    // ----------------------------------------
    localparam logic [63:0] qw = 64'h0123_4567_89ab_cdef;
    logic clk_i, nrst_i, pci_error_signal_enable_i, diag_enable_i, wr_valid_i, wr_cpu_i, rd_valid_i;
    logic rd_cpu_i, wr_ready_o, rd_ready_o, mem_rd_o, mem_wr_o, mem_rvalid_i, rd_done_o, serr_n_o;
    logic [1:0] correction_mode_select_i, error_signal_enable_i, status_clear_i, error_status_o;
    logic [63:0] wr_data_i, mem_wdata_o, mem_rdata_i, rd_data_o, flip, rdat, lwd;
    logic [7:0] wr_be_i, wr_cpu_chk_i, mem_wchk_o, mem_rchk_i, rd_chk_o, rchk, lwc;
    logic [2:0] wr_cs_i, rd_cs_i, mem_cs_o, multibit_fail_chipsel_o, singlebit_fail_chipsel_o;
    int error_cnt, n_checks, serr_cnt, wcnt, rcnt, n0, rlat, clat;
    dec_ecc_ctrl dut (.*);
    dec_mem_model mem (.clk_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_cs_i(mem_cs_o),
        .mem_wdata_i(mem_wdata_o), .mem_wchk_i(mem_wchk_o), .flip_i(flip),
        .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i), .rchk_o(mem_rchk_i),
        .last_wdata_o(lwd), .last_wchk_o(lwc), .wr_cnt_o(wcnt), .rd_cnt_o(rcnt));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(negedge serr_n_o) serr_cnt++;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // requests held from a falling edge until the accepting rising edge has passed
    task wr(input logic [63:0] d, input logic [7:0] be, input logic [2:0] cs, input logic cpu);
        int n;
        int w0;
        {wr_data_i, wr_be_i, wr_cs_i, wr_cpu_i, wr_valid_i} = {d, be, cs, cpu, 1'b1};
        w0 = wcnt;
        #1;
        for (n = 0; n < 20 && wr_ready_o !== 1'b1; n++) @(negedge clk_i);
        chk(wr_ready_o, 1'b1);
        @(negedge clk_i);
        wr_valid_i = 1'b0;
        for (n = 0; n < 30 && wcnt == w0; n++) @(negedge clk_i);
        chk(wcnt - w0, 1);
        @(negedge clk_i);
    endtask : wr
    task rd(input logic [2:0] cs, input logic cpu, input logic [63:0] f);
        int n;
        {rd_cs_i, rd_cpu_i, rd_valid_i, flip} = {cs, cpu, 1'b1, f};
        #1;
        for (n = 0; n < 20 && rd_ready_o !== 1'b1; n++) @(negedge clk_i);
        chk(rd_ready_o, 1'b1);
        @(negedge clk_i);
        rd_valid_i = 1'b0;
        for (n = 0; n < 30 && rd_done_o !== 1'b1; n++) @(negedge clk_i);
        chk(rd_done_o, 1'b1);
        rlat = n;
        rdat = rd_data_o;
        rchk = rd_chk_o;
        repeat (4) @(negedge clk_i); // scrub lands after the return; serr lands with a corrected return, a clock after an uncorrected one
        flip = '0;
    endtask : rd
    task clear(input logic [1:0] mode);
        {status_clear_i, correction_mode_select_i} = {2'h3, mode};
        @(negedge clk_i);
        status_clear_i = 2'h0;
        @(negedge clk_i);
        serr_cnt = 0;
    endtask : clear
    task t_reset();
        chk(error_status_o, 2'h0);
        chk({multibit_fail_chipsel_o, singlebit_fail_chipsel_o, serr_n_o}, 7'h01);
    endtask : t_reset
    task t_single();
        {error_signal_enable_i, pci_error_signal_enable_i} = 3'b101;
        clear(2'h2);
        wr(qw, 8'hff, 3'h1, 1'b0);
        rd(3'h1, 1'b0, 64'h20);
        clat = rlat;
        chk(rdat, qw);
        chk(error_status_o, 2'h2);
        chk(singlebit_fail_chipsel_o, 3'h1);
        chk(serr_cnt, 1);
        wr(qw, 8'hff, 3'h3, 1'b0);
        rd(3'h3, 1'b0, 64'h1);
        chk(singlebit_fail_chipsel_o, 3'h1);
        chk(serr_cnt, 1);
        clear(2'h2);
        chk(error_status_o, 2'h0);
        rd(3'h3, 1'b0, 64'h1);
        chk(singlebit_fail_chipsel_o, 3'h3);
        chk(serr_cnt, 1);
    endtask : t_single
    task t_multi();
        clear(2'h2);
        rd(3'h3, 1'b0, 64'h3);
        chk({error_status_o, multibit_fail_chipsel_o}, 5'h0b);
        chk(serr_cnt, 0);
        {error_signal_enable_i, pci_error_signal_enable_i} = 3'b010;
        clear(2'h2);
        rd(3'h3, 1'b0, 64'h3);
        chk(serr_cnt, 0);
        pci_error_signal_enable_i = 1'b1;
        clear(2'h2);
        rd(3'h3, 1'b0, 64'h3);
        chk(serr_cnt, 1);
    endtask : t_multi
    task t_modes();
        clear(2'h1);
        rd(3'h1, 1'b0, 64'h100);
        chk(rdat, qw ^ 64'h100);
        chk(rlat + 1, clat);
        chk(error_status_o, 2'h2);
        clear(2'h2);
        wr(qw, 8'hff, 3'h2, 1'b0);
        wr(64'h55, 8'h01, 3'h2, 1'b0);
        rd(3'h2, 1'b0, 64'h0);
        chk(rdat, {qw[63:8], 8'h55});
        clear(2'h3);
        n0 = wcnt;
        rd(3'h1, 1'b0, 64'h8000);
        chk(rdat, qw);
        chk(wcnt - n0, 1);
        chk(lwd, qw);
        clear(2'h0);
        wr(qw, 8'hff, 3'h6, 1'b0);
        chk(lwc, 8'h00);
        rd(3'h6, 1'b0, 64'h1);
        chk(rdat, qw ^ 64'h1);
        chk(error_status_o, 2'h0);
    endtask : t_modes
    task t_diag_cpu();
        diag_enable_i = 1'b1;
        clear(2'h2);
        wr(qw, 8'hff, 3'h4, 1'b0);
        chk(lwc, 8'h00);
        n0 = rcnt;
        wr(64'h7700, 8'h02, 3'h4, 1'b0);
        chk({rcnt - n0, lwc}, {32'h1, 8'h00});
        rd(3'h4, 1'b0, 64'h2);
        chk(rdat, {qw[63:16], 8'h77, qw[7:0]} ^ 64'h2);
        diag_enable_i = 1'b0;
        wr_cpu_chk_i = 8'h5a;
        wr(qw, 8'hff, 3'h5, 1'b1);
        chk(lwc, 8'h5a);
        rd(3'h5, 1'b1, 64'h10);
        chk(rdat, qw ^ 64'h10);
        chk(rchk, 8'h5a);
    endtask : t_diag_cpu
    task results();
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    initial begin
        {nrst_i, pci_error_signal_enable_i, diag_enable_i, wr_valid_i, wr_cpu_i, rd_valid_i} = '0;
        {rd_cpu_i, correction_mode_select_i, error_signal_enable_i, status_clear_i} = '0;
        {wr_data_i, flip, wr_be_i, wr_cpu_chk_i, wr_cs_i, rd_cs_i} = '0;
        {error_cnt, n_checks, serr_cnt} = '0;
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_single();
        t_multi();
        t_modes();
        t_diag_cpu();
        results();
    end
    // watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        results();
    end
endmodule : ddr_ecc_check_scrub_control_test
bind dec_ecc_ctrl dec_ecc_ctrl_assertions u_chk (.*);

// ==== tb/dec_ecc_ctrl_assertions.sv ====
// checker: concurrent assertions on the ecc control block ports
`timescale 1ns/100ps
module dec_ecc_ctrl_assertions (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] correction_mode_select_i,
    input wire logic [1:0] error_signal_enable_i,
    input wire logic pci_error_signal_enable_i,
    input wire logic diag_enable_i,
    input wire logic [1:0] status_clear_i,
    input wire logic wr_valid_i,
    input wire logic rd_valid_i,
    input wire logic rd_ready_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_wchk_o,
    input wire logic [1:0] error_status_o,
    input wire logic [2:0] multibit_fail_chipsel_o,
    input wire logic [2:0] singlebit_fail_chipsel_o,
    input wire logic serr_n_o
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_serr_pci_gate: assert property (!serr_n_o |-> $past(pci_error_signal_enable_i))
        else $error("serr low without pci enable");
    a_serr_sel: assert property ($fell(serr_n_o) |-> $past(error_signal_enable_i) != 2'h0)
        else $error("serr low with reporting off");
    a_serr_one_pulse: assert property (!serr_n_o |=> serr_n_o)
        else $error("serr held longer than a pulse");
    a_serr_cause: assert property ($fell(serr_n_o) |-> error_status_o != 2'h0)
        else $error("serr without a logged error");
    a_mb_cs_hold: assert property (error_status_o[0] && $past(error_status_o[0])
        && !$past(status_clear_i[0]) |-> $stable(multibit_fail_chipsel_o))
        else $error("multi-bit chip select moved");
    a_sb_cs_hold: assert property (error_status_o[1] && $past(error_status_o[1])
        && !$past(status_clear_i[1]) |-> $stable(singlebit_fail_chipsel_o))
        else $error("single-bit chip select moved");
    a_diag_zero: assert property (mem_wr_o && $past(diag_enable_i)
        |-> mem_wchk_o == 8'h00) else $error("diagnostic write with nonzero check byte");
    a_off_zero: assert property (mem_wr_o && $past(correction_mode_select_i) == 2'h0
        |-> mem_wchk_o == 8'h00) else $error("check byte stored with ecc off");
    a_rd_issue: assert property (rd_valid_i && rd_ready_o && !wr_valid_i |=> mem_rd_o)
        else $error("taken read not issued next cycle");
    c_serr: cover property ($fell(serr_n_o));
    c_single: cover property ($rose(error_status_o[1]));
    c_multi: cover property ($rose(error_status_o[0]));
endmodule : dec_ecc_ctrl_assertions

// ==== tb/dec_mem_model.sv ====
// partner model: ecc dimm rows answering controller reads after three cycles
`timescale 1ns/100ps
module dec_mem_model (
    input wire logic clk_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [2:0] mem_cs_i,
    input wire logic [63:0] mem_wdata_i,
    input wire logic [7:0] mem_wchk_i,
    input wire logic [63:0] flip_i,
    output logic rvalid_o,
    output logic [63:0] rdata_o,
    output logic [7:0] rchk_o,
    output logic [63:0] last_wdata_o,
    output logic [7:0] last_wchk_o,
    output int wr_cnt_o,
    output int rd_cnt_o
);
    // ----------------------------------------
    // storage and read return
    // ----------------------------------------
    logic [63:0] mdata [8];
    logic [7:0] mchk [8];
    logic [2:0] pend [2];
    logic [1:0] rq = 2'h0;
    initial begin
        {rvalid_o, rdata_o, rchk_o} = '0;
        wr_cnt_o = 0;
        rd_cnt_o = 0;
    end
    // flip mask corrupts returned data only; stored values stay clean
    always @(posedge clk_i) begin
        rq <= {rq[0], mem_rd_i};
        pend <= '{mem_cs_i, pend[0]};
        rvalid_o <= rq[1];
        rdata_o <= rq[1] ? mdata[pend[1]] ^ flip_i : ~rdata_o; // released bus never holds
        rchk_o <= rq[1] ? mchk[pend[1]] : ~rchk_o;
        if (mem_rd_i) rd_cnt_o <= rd_cnt_o + 1;
        if (mem_wr_i) begin
            mdata[mem_cs_i] <= mem_wdata_i; // check byte kept beside its quadword
            mchk[mem_cs_i] <= mem_wchk_i;
            last_wdata_o <= mem_wdata_i;
            last_wchk_o <= mem_wchk_i;
            wr_cnt_o <= wr_cnt_o + 1;
        end
    end
endmodule : dec_mem_model
